// File: verilog/irq_xfer_pkg.sv
// constants and types shared by the interrupt level / auto transfer block
`default_nettype none
package irq_xfer_pkg;
	// -----------------------------------------------------------------
	// register map (index = printed offset, byte address = 4 * index)
	// -----------------------------------------------------------------
	localparam logic [7:0]  CTRL_IDX_FIRST = 8'hb0;
	localparam int          NSRC           = 16;
	localparam logic [2:0]  PRIO_NONE      = 3'h7;
	localparam logic [3:0]  CHAN_RESET     = 4'h0;
	localparam logic [1:0]  END_NONE       = 2'h0;
	localparam logic [1:0]  END_COUNT      = 2'h1;
	localparam logic [1:0]  END_STOP       = 2'h3;
	localparam logic [1:0]  RD_TOP_BITS    = 2'h3;
	localparam int          WR_CHAN_LSB    = 4;
	localparam int          WR_AUTO_BIT    = 3;
	// -----------------------------------------------------------------
	// descriptor layout in internal ram
	// -----------------------------------------------------------------
	localparam logic [23:0] DESC_BASE      = 24'h000100;
	localparam logic [2:0]  DESC_LAST_BYTE = 3'h7;
	localparam int          MODE_IO_HOLD   = 4;
	localparam int          MODE_WIDTH     = 3;
	localparam int          MODE_BUF_HOLD  = 2;
	localparam int          MODE_DIR       = 1;
	localparam int          MODE_STOP      = 0;
	// -----------------------------------------------------------------
	// transfer engine states, gray coded along the path from ST_IDLE to ST_DONE
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LOAD  = 3'b001,
		ST_CHECK = 3'b011,
		ST_GET   = 3'b010,
		ST_PUT   = 3'b110,
		ST_SAVE  = 3'b111,
		ST_DONE  = 3'b101
	} eng_state_t;
endpackage
`default_nettype wire

// File: verilog/irq_xfer_ctrl.sv
// interrupt level control with descriptor driven automatic i/o transfer
`timescale 1ns/1ps
`default_nettype none
module irq_xfer_ctrl
	import irq_xfer_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [15:0] irq_req,
	input  wire logic [15:0] stop_req,
	output logic      [2:0]  cpu_level,
	output logic      [3:0]  cpu_src,
	input  wire logic        cpu_ack,
	output logic             isr_go,
	output logic      [3:0]  isr_src,
	output logic      [15:0] svc_clear,
	output logic      [23:0] mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_ready
);
	// -----------------------------------------------------------------
	// control registers and bus slave
	// -----------------------------------------------------------------
	logic [2:0]  prio_reg [NSRC];
	logic [2:0]  prio_next [NSRC];
	logic        auto_reg [NSRC];
	logic        auto_next [NSRC];
	logic [3:0]  chan_reg [NSRC];
	logic [3:0]  chan_next [NSRC];
	logic [1:0]  endc_reg [NSRC];
	logic [1:0]  endc_next [NSRC];
	logic        wait_reg;
	logic        wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [7:0]  bus_idx;
	logic        bus_hit;
	logic        bus_take;

	// engine state, declared here because the register group reads it
	eng_state_t  st_reg;
	eng_state_t  st_next;
	logic [3:0]  src_reg;
	logic [3:0]  src_next;
	logic [1:0]  end_reg;
	logic [1:0]  end_next;

	// waitrequest drops for exactly one cycle per request
	always_comb
	begin
		bus_idx    = avs_address[9:2];
		bus_hit    = bus_idx[7:4] == CTRL_IDX_FIRST[7:4];
		bus_take   = (avs_read || avs_write) && !wait_reg;
		wait_next  = !((avs_read || avs_write) && wait_reg);
		rdata_next = rdata_reg;
		if ((avs_read || avs_write) && wait_reg)
		begin
			rdata_next = 32'h0000_0000;
			if (avs_read && bus_hit)
				rdata_next[7:0] = {RD_TOP_BITS,
					endc_reg[bus_idx[3:0]], auto_reg[bus_idx[3:0]],
					prio_reg[bus_idx[3:0]]};
		end
		for (int i = 0; i < NSRC; i++)
		begin
			prio_next[i] = prio_reg[i];
			auto_next[i] = auto_reg[i];
			chan_next[i] = chan_reg[i];
			endc_next[i] = endc_reg[i];
			// writes land only at the edge that sees waitrequest low
			if (bus_take && avs_write && bus_hit && avs_byteenable[0]
				&& bus_idx[3:0] == 4'(i))
			begin
				prio_next[i] = avs_writedata[2:0];
				auto_next[i] = avs_writedata[WR_AUTO_BIT];
				chan_next[i] = avs_writedata[WR_CHAN_LSB +: 4];
			end
			// hardware end beats a software write in the same cycle
			if (st_reg == ST_DONE && end_reg != END_NONE
				&& src_reg == 4'(i))
			begin
				endc_next[i] = end_reg;
				auto_next[i] = 1'b0;
			end
		end
	end

	// register the control group
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NSRC; i++)
			begin
				prio_reg[i] <= PRIO_NONE;
				auto_reg[i] <= 1'b0;
				chan_reg[i] <= CHAN_RESET;
				endc_reg[i] <= END_NONE;
			end
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			prio_reg  <= prio_next;
			auto_reg  <= auto_next;
			chan_reg  <= chan_next;
			endc_reg  <= endc_next;
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;

	// -----------------------------------------------------------------
	// arbitration and transfer engine
	// -----------------------------------------------------------------
	logic [2:0]  best_lvl;
	logic [3:0]  best_src;
	logic [2:0]  bidx_reg;
	logic [2:0]  bidx_next;
	logic [63:0] desc_reg;
	logic [63:0] desc_next;
	logic [15:0] data_reg;
	logic [15:0] data_next;
	logic [2:0]  lvl_reg;
	logic [2:0]  lvl_next;
	logic [3:0]  csrc_reg;
	logic [3:0]  csrc_next;
	logic        go_reg;
	logic        go_next;
	logic [3:0]  gsrc_reg;
	logic [3:0]  gsrc_next;
	logic [15:0] clr_reg;
	logic [15:0] clr_next;
	logic [23:0] addr_reg;
	logic [23:0] addr_next;
	logic        rd_reg;
	logic        rd_next;
	logic        wr_reg;
	logic        wr_next;
	logic [7:0]  wd_reg;
	logic [7:0]  wd_next;
	logic        acc_done;
	logic        item_last;
	logic [7:0]  mode;
	logic [15:0] step;
	logic [23:0] io_addr;
	logic [23:0] buf_addr;

	// lowest level wins, lowest source number breaks ties
	always_comb
	begin
		best_lvl = PRIO_NONE;
		best_src = 4'h0;
		for (int i = 0; i < NSRC; i++)
			if (irq_req[i] && prio_reg[i] < best_lvl)
			begin
				best_lvl = prio_reg[i];
				best_src = 4'(i);
			end
	end

	// one memory access at a time; request held until mem_ready
	always_comb
	begin
		st_next   = st_reg;
		src_next  = src_reg;
		end_next  = end_reg;
		bidx_next = bidx_reg;
		desc_next = desc_reg;
		data_next = data_reg;
		addr_next = addr_reg;
		rd_next   = rd_reg;
		wr_next   = wr_reg;
		wd_next   = wd_reg;
		go_next   = 1'b0;
		gsrc_next = gsrc_reg;
		clr_next  = 16'h0000;
		lvl_next  = PRIO_NONE;  // others wait while a run is busy
		csrc_next = csrc_reg;
		acc_done  = (rd_reg || wr_reg) && mem_ready;
		mode      = desc_reg[31:24];
		item_last = bidx_reg[0] == mode[MODE_WIDTH];
		step      = {14'h0000, mode[MODE_WIDTH], !mode[MODE_WIDTH]};
		io_addr   = {8'h00, desc_reg[47:32] + {15'h0000, bidx_reg[0]}};
		buf_addr  = desc_reg[23:0] + {23'h000000, bidx_reg[0]};
		case (st_reg)
			ST_IDLE:
			begin
				lvl_next  = best_lvl;
				csrc_next = best_src;
				if (cpu_ack && lvl_reg != PRIO_NONE)
				begin
					src_next = csrc_reg;
					if (auto_reg[csrc_reg])
					begin
						st_next   = ST_LOAD;
						end_next  = END_NONE;
						bidx_next = 3'h0;
						lvl_next  = PRIO_NONE;
					end
					else
					begin
						go_next   = 1'b1;
						gsrc_next = csrc_reg;
					end
				end
			end
			ST_LOAD:
			begin
				if (!rd_reg)
				begin
					rd_next   = 1'b1;
					addr_next = {DESC_BASE[23:7], chan_reg[src_reg],
						bidx_reg};
				end
				else if (acc_done)
				begin
					rd_next   = 1'b0;
					desc_next[{bidx_reg, 3'b000} +: 8] = mem_rdata;
					bidx_next = bidx_reg + 3'h1;
					if (bidx_reg == DESC_LAST_BYTE)
						st_next = ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				bidx_next = 3'h0;
				if (mode[MODE_STOP] && stop_req[src_reg])
				begin
					end_next = END_STOP;
					st_next  = ST_SAVE;
				end
				else
				begin
					// zero wraps to ffff, giving 65536 items
					desc_next[63:48] = desc_reg[63:48] - 16'h0001;
					st_next = ST_GET;
				end
			end
			ST_GET:
			begin
				if (!rd_reg)
				begin
					rd_next   = 1'b1;
					addr_next = mode[MODE_DIR] ? buf_addr : io_addr;
				end
				else if (acc_done)
				begin
					rd_next   = 1'b0;
					data_next[{bidx_reg[0], 3'b000} +: 8] = mem_rdata;
					bidx_next = item_last ? 3'h0 : bidx_reg + 3'h1;
					if (item_last)
						st_next = ST_PUT;
				end
			end
			ST_PUT:
			begin
				if (!wr_reg)
				begin
					wr_next   = 1'b1;
					addr_next = mode[MODE_DIR] ? io_addr : buf_addr;
					wd_next   = data_reg[{bidx_reg[0], 3'b000} +: 8];
				end
				else if (acc_done)
				begin
					wr_next   = 1'b0;
					bidx_next = item_last ? 3'h0 : bidx_reg + 3'h1;
					if (item_last)
					begin
						if (!mode[MODE_IO_HOLD])
							desc_next[47:32] = desc_reg[47:32] + step;
						if (!mode[MODE_BUF_HOLD])
							desc_next[15:0] = desc_reg[15:0] + step;
						clr_next[src_reg] = 1'b1;
						if (desc_reg[63:48] == 16'h0000)
							end_next = END_COUNT;
						st_next = ST_SAVE;
					end
				end
			end
			ST_SAVE:
			begin
				// write the whole descriptor back so pointers persist
				if (!wr_reg)
				begin
					wr_next   = 1'b1;
					addr_next = {DESC_BASE[23:7], chan_reg[src_reg],
						bidx_reg};
					wd_next   = desc_reg[{bidx_reg, 3'b000} +: 8];
				end
				else if (acc_done)
				begin
					wr_next   = 1'b0;
					bidx_next = bidx_reg + 3'h1;
					if (bidx_reg == DESC_LAST_BYTE)
						st_next = ST_DONE;
				end
			end
			ST_DONE:
			begin
				// status and handler pulse both land at this edge
				st_next = ST_IDLE;
				if (end_reg != END_NONE)
				begin
					go_next   = 1'b1;
					gsrc_next = src_reg;
				end
			end
			default:
				st_next = ST_IDLE;
		endcase
	end

	// register the engine group
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_reg   <= ST_IDLE;
			src_reg  <= 4'h0;
			end_reg  <= END_NONE;
			bidx_reg <= 3'h0;
			desc_reg <= 64'h0;
			data_reg <= 16'h0000;
			addr_reg <= 24'h000000;
			rd_reg   <= 1'b0;
			wr_reg   <= 1'b0;
			wd_reg   <= 8'h00;
			go_reg   <= 1'b0;
			gsrc_reg <= 4'h0;
			clr_reg  <= 16'h0000;
			lvl_reg  <= PRIO_NONE;
			csrc_reg <= 4'h0;
		end
		else
		begin
			st_reg   <= st_next;
			src_reg  <= src_next;
			end_reg  <= end_next;
			bidx_reg <= bidx_next;
			desc_reg <= desc_next;
			data_reg <= data_next;
			addr_reg <= addr_next;
			rd_reg   <= rd_next;
			wr_reg   <= wr_next;
			wd_reg   <= wd_next;
			go_reg   <= go_next;
			gsrc_reg <= gsrc_next;
			clr_reg  <= clr_next;
			lvl_reg  <= lvl_next;
			csrc_reg <= csrc_next;
		end
	end

	assign cpu_level = lvl_reg;
	assign cpu_src   = csrc_reg;
	assign isr_go    = go_reg;
	assign isr_src   = gsrc_reg;
	assign svc_clear = clr_reg;
	assign mem_addr  = addr_reg;
	assign mem_rd    = rd_reg;
	assign mem_wr    = wr_reg;
	assign mem_wdata = wd_reg;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	prio_reset_a: assert property (@(posedge clk)
		!resetn |=> prio_reg[5] == PRIO_NONE && !auto_reg[5]
		&& endc_reg[5] == END_NONE)
		else $error("control register not at reset value");
	end_status_a: assert property (@(posedge clk) disable iff (!resetn)
		st_reg == ST_DONE && end_reg != END_NONE |=>
		!auto_reg[$past(src_reg)]
		&& endc_reg[$past(src_reg)] == $past(end_reg))
		else $error("end status not recorded");
	end_branch_a: assert property (@(posedge clk) disable iff (!resetn)
		st_reg == ST_DONE && end_reg != END_NONE |=>
		isr_go && isr_src == $past(src_reg) && st_reg == ST_IDLE)
		else $error("no handler pulse after run end");
	auto_start_a: assert property (@(posedge clk) disable iff (!resetn)
		st_reg == ST_IDLE && cpu_ack && lvl_reg != PRIO_NONE
		|=> (st_reg == ST_LOAD) == auto_reg[$past(csrc_reg)]
		&& isr_go == !auto_reg[$past(csrc_reg)])
		else $error("wrong service choice");
	desc_addr_a: assert property (@(posedge clk) disable iff (!resetn)
		st_reg == ST_LOAD && rd_reg |->
		mem_addr == DESC_BASE + {17'h00000, chan_reg[src_reg], 3'b000}
		+ {21'h000000, bidx_reg})
		else $error("descriptor address wrong");
	io_region_a: assert property (@(posedge clk) disable iff (!resetn)
		(st_reg == ST_GET && rd_reg && !mode[MODE_DIR])
		|| (st_reg == ST_PUT && wr_reg && mode[MODE_DIR])
		|-> mem_addr[23:16] == 8'h00)
		else $error("i/o access outside first 64k");
	count_dec_a: assert property (@(posedge clk) disable iff (!resetn)
		st_reg == ST_CHECK && st_next == ST_GET |=>
		desc_reg[63:48] == $past(desc_reg[63:48]) - 16'h0001)
		else $error("count not decremented");
	mem_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		(rd_reg || wr_reg) && !mem_ready |=>
		(rd_reg || wr_reg) && $stable(mem_addr))
		else $error("memory request dropped early");
endmodule
`default_nettype wire

// File: test/mem_model.sv
// behavioural internal ram answering the block's memory master
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic [23:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	output logic             mem_ready
);
	logic [7:0] mem [0:65535];
	int         n_acc;
	int         bad_addr;
	int         waited;
	// clear ram so unwritten bytes compare as known zeros
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h00;
		n_acc = 0;
		bad_addr = 0;
		waited = 0;
		mem_ready = 1'b0;
		mem_rdata = 8'h00;
	end
	// slow mode adds wait cycles so the master must hold its request
	always @(posedge clk)
	begin
		if ((mem_rd || mem_wr) && !mem_ready && waited >= (slow ? 2 : 0))
		begin
			mem_ready <= 1'b1;
			n_acc <= n_acc + 1;
			if (mem_addr[23:16] != 8'h00) bad_addr <= bad_addr + 1;
			if (mem_rd) mem_rdata <= mem[mem_addr[15:0]];
			if (mem_wr) mem[mem_addr[15:0]] <= mem_wdata;
			waited <= 0;
		end
		else
		begin
			// read data is only valid with ready; it toggles afterwards
			mem_ready <= 1'b0;
			mem_rdata <= ~mem_rdata;
			waited <= ((mem_rd || mem_wr) && !mem_ready) ? waited + 1 : 0;
		end
	end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the interrupt level and auto transfer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import irq_xfer_pkg::*;
	typedef struct {logic [9:0] a; logic [3:0] be; logic [7:0] d, e;} row_t;
	logic        clk = 0, resetn = 0, avs_read = 0, avs_write = 0;
	logic        cpu_ack = 0, slow = 0, avs_waitrequest, isr_go;
	logic        mem_rd, mem_wr, mem_ready;
	logic [9:0]  avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, rd;
	logic [3:0]  avs_byteenable = 0, cpu_src, isr_src;
	logic [15:0] irq_req = 0, stop_req = 0, svc_clear;
	logic [2:0]  cpu_level;
	logic [23:0] mem_addr;
	logic [7:0]  mem_wdata, mem_rdata;
	int          num_errors = 0, samples_checked = 0, cycles = 0, svc_n = 0;
	// write then read back; channel bits never show on a read
	row_t        rows [6] = '{
		'{10'h2c0, 4'hf, 8'hf2, 8'hc2},
		'{10'h2c4, 4'hf, 8'h08, 8'hc8},
		'{10'h2fc, 4'hf, 8'h5e, 8'hce},
		'{10'h2c8, 4'hf, 8'h06, 8'hc6},
		'{10'h2c8, 4'h0, 8'h01, 8'hc6},
		'{10'h000, 4'hf, 8'h5a, 8'h00}};

	always #25 clk = ~clk;

	irq_xfer_ctrl u_dut (.clk(clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq_req(irq_req),
		.stop_req(stop_req), .cpu_level(cpu_level), .cpu_src(cpu_src),
		.cpu_ack(cpu_ack), .isr_go(isr_go), .isr_src(isr_src),
		.svc_clear(svc_clear), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ready(mem_ready));

	mem_model u_mem (.clk(clk), .slow(slow), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ready(mem_ready));

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic complete_run();
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// cycle ceiling also bounds every handshake wait below
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (svc_clear !== 16'h0) svc_n <= svc_n + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end

	// request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [3:0] be, input logic [7:0] d);
		avs_address <= a;
		avs_byteenable <= be;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [9:0] ra(input logic [7:0] s);
		ra = {CTRL_IDX_FIRST + s, 2'b00};
	endfunction

	task automatic rw(input logic [7:0] s, input logic [7:0] d);
		bus(1'b1, ra(s), 4'hf, d);
	endtask

	task automatic rchk(input logic [7:0] s, input logic [7:0] e);
		bus(1'b0, ra(s), 4'hf, 8'h00);
		check(rd, e);
	endtask

	// level lags a cycle, so let a run force it to 7 before looking
	task automatic ack();
		repeat (2) @(posedge clk);
		while (cpu_level === 3'h7) @(posedge clk);
		cpu_ack <= 1'b1;
		@(posedge clk);
		cpu_ack <= 1'b0;
	endtask

	task automatic wait_isr(input logic [3:0] s);
		while (isr_go !== 1'b1) @(posedge clk);
		check(isr_src, s);
	endtask

	task automatic desc(input int c, input logic [63:0] v);
		for (int k = 0; k < 8; k++) u_mem.mem[256 + 8 * c + k] = v[8 * k +: 8];
	endtask

	function automatic logic [63:0] dget(input int c);
		for (int k = 0; k < 8; k++) dget[8 * k +: 8] = u_mem.mem[256 + 8 * c + k];
	endfunction

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		check(cpu_level, 3'h7);
		rchk(0, 8'hc7);
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].be, rows[i].d);
			bus(1'b0, rows[i].a, 4'hf, 8'h00);
			check(rd, rows[i].e);
		end
		// two ordinary requests, lower code wins
		rw(3, 8'h02);
		rw(5, 8'hf1);
		irq_req <= 16'h0028;
		repeat (3) @(posedge clk);
		check({cpu_src, cpu_level}, {4'h5, 3'h1});
		ack();
		wait_isr(5);
		irq_req <= 16'h0008;
		repeat (3) @(posedge clk);
		check({cpu_src, cpu_level}, {4'h3, 3'h2});
		ack();
		wait_isr(3);
		rw(3, 8'h07);
		repeat (3) @(posedge clk);
		check(cpu_level, 3'h7);
		irq_req <= 16'h0;
		check(u_mem.n_acc, 0);
		// one byte in, stop ignored, buffer low half wraps
		u_mem.mem[16'h0040] = 8'h5a;
		desc(1, {16'h0001, 16'h0040, 8'h00, 24'h00ffff});
		rw(4, 8'h1b);
		stop_req <= 16'h0010;
		irq_req <= 16'h0010;
		ack();
		wait_isr(4);
		check(u_mem.mem[16'hffff], 8'h5a);
		check(dget(1), {32'h00000041, 32'h00000000});
		rchk(4, 8'hd3);
		check(svc_n, 1);
		irq_req <= 16'h0;
		stop_req <= 16'h0;
		// stop request ends the run before anything moves
		desc(7, {16'h0005, 16'h0060, 8'h01, 24'h000400});
		rw(6, 8'h7c);
		stop_req <= 16'h0040;
		irq_req <= 16'h0040;
		ack();
		wait_isr(6);
		check(dget(7), {16'h0005, 16'h0060, 8'h01, 24'h000400});
		rchk(6, 8'hf4);
		check(svc_n, 1);
		irq_req <= 16'h0;
		stop_req <= 16'h0;
		// zero count wraps: one item moves, run goes on, no handler
		u_mem.mem[16'h0070] = 8'hc3;
		desc(3, {16'h0000, 16'h0070, 8'h10, 24'h000500});
		rw(6, 8'h3c);
		irq_req <= 16'h0040;
		ack();
		repeat (2) @(posedge clk);
		while (cpu_level === 3'h7) @(posedge clk);
		check(dget(3), {16'hffff, 16'h0070, 8'h10, 24'h000501});
		check(u_mem.mem[16'h0500], 8'hc3);
		rchk(6, 8'hfc);
		irq_req <= 16'h0;
		// two words out on held pointers, slow memory
		slow <= 1'b1;
		u_mem.mem[16'h0300] = 8'h34;
		u_mem.mem[16'h0301] = 8'h12;
		desc(15, {16'h0002, 16'h0050, 8'h1e, 24'h000300});
		rw(8, 8'hfd);
		irq_req <= 16'h0100;
		ack();
		ack();
		wait_isr(8);
		check({u_mem.mem[16'h52], u_mem.mem[16'h51], u_mem.mem[16'h50]},
			24'h001234);
		check(dget(15), {16'h0, 16'h0050, 8'h1e, 24'h000300});
		rchk(8, 8'hd5);
		check(svc_n, 4);
		check(u_mem.bad_addr, 0);
		irq_req <= 16'h0;
		// second reset clears the recorded end code
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rchk(4, 8'hc7);
		complete_run();
	end
endmodule
`default_nettype wire
